/* File: hw/tmrctl_top.sv */
/*
  Two-timer control block: timer one (8-bit count with reload and
  prescaler) and the second timer (clear-and-stop, source select, large
  divider), with the register port that software uses.
  Assumes: i_slow_clk and i_fast_rc_clk are levels synchronous to
  i_core_clk and slower than half its rate; i_core_clk is the system clock.
*/
`include "tmrctl_params.svh"

module tmrctl_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_slow_clk,
  input  wire logic        i_fast_rc_clk,
  output logic             o_t1_overflow,
  output logic      [7:0]  o_t1_count,
  output logic             o_t2_overflow,
  output logic      [14:0] o_t2_count
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // last prescaler cycle, counted in system clocks (two per prescaled step)
  function automatic logic [8:0] t1_last(input logic [3:0] div);
    logic [8:0] steps;
    steps = 9'h000;
    if (div[3]) begin
      steps = 9'h100;
    end else begin
      steps = 9'h001 << div[2:0];
    end
    t1_last = 9'((10'(steps) * 10'(`TMRCTL_SYS_PRE_DIV)) - 10'h001);
  endfunction : t1_last

  // one-cycle pulse on the rising level of a sampled clock pin
  function automatic logic rise(input logic now, input logic prev);
    rise = now && !prev;
  endfunction : rise

  // readback image of the timer one control register
  function automatic logic [7:0] t1_ctl_image(input logic halt, input logic [3:0] div);
    t1_ctl_image = 8'h00;
    t1_ctl_image[`TMRCTL_T1_HALT_BIT] = halt;
    t1_ctl_image[`TMRCTL_T1_DIV_MSB:`TMRCTL_T1_DIV_LSB] = div;
  endfunction : t1_ctl_image

  // readback image of the second timer control register
  function automatic logic [7:0] t2_ctl_image(input logic clr, input logic [1:0] src,
                                              input logic [1:0] div);
    t2_ctl_image = 8'h00;
    t2_ctl_image[`TMRCTL_T2_CLR_BIT] = clr;
    t2_ctl_image[`TMRCTL_T2_CKS_MSB:`TMRCTL_T2_CKS_LSB] = src;
    t2_ctl_image[`TMRCTL_T2_DIV_MSB:`TMRCTL_T2_DIV_LSB] = div;
  endfunction : t2_ctl_image

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [7:0]  t1_count_q;
  logic [7:0]  t1_reload_q;
  logic        t1_halt_q;
  logic [3:0]  t1_div_q;
  logic        t2_clr_q;
  tmrctl_pkg::tmrctl_src_t t2_src_q;
  logic [1:0]  t2_div_q;

  logic        wr_count;
  logic        wr_reload;
  logic        wr_t1ctl;
  logic        wr_second_timer_control;

  assign wr_count  = i_wr && hit(i_addr, `TMRCTL_ADDR_T1_COUNT);
  assign wr_reload = i_wr && hit(i_addr, `TMRCTL_ADDR_T1_RELOAD);
  assign wr_t1ctl  = i_wr && hit(i_addr, `TMRCTL_ADDR_T1_CTL);
  assign wr_second_timer_control  = i_wr && hit(i_addr, `TMRCTL_ADDR_T2_CTL);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t1_reload_q <= `TMRCTL_RST_T1_RELOAD;
    end else if (wr_reload) begin
      t1_reload_q <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t1_halt_q <= `TMRCTL_RST_T1_HALT;
    end else if (wr_t1ctl) begin
      t1_halt_q <= i_wdata[`TMRCTL_T1_HALT_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t1_div_q <= `TMRCTL_RST_T1_DIV;
    end else if (wr_t1ctl) begin
      t1_div_q <= i_wdata[`TMRCTL_T1_DIV_MSB:`TMRCTL_T1_DIV_LSB];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t2_clr_q <= `TMRCTL_RST_T2_CLR;
    end else if (wr_second_timer_control) begin
      t2_clr_q <= i_wdata[`TMRCTL_T2_CLR_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t2_src_q <= tmrctl_pkg::tmrctl_src_t'(`TMRCTL_RST_T2_CKS);
    end else if (wr_second_timer_control) begin
      t2_src_q <= tmrctl_pkg::tmrctl_src_t'(i_wdata[`TMRCTL_T2_CKS_MSB:`TMRCTL_T2_CKS_LSB]);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t2_div_q <= `TMRCTL_RST_T2_DIV;
    end else if (wr_second_timer_control) begin
      t2_div_q <= i_wdata[`TMRCTL_T2_DIV_MSB:`TMRCTL_T2_DIV_LSB];
    end
  end

  // ----------------------------------------------------------------------
  // timer one prescaler
  // ----------------------------------------------------------------------
  logic [8:0] t1_pre_q;
  logic       t1_step;

  assign t1_step = !t1_halt_q && (t1_pre_q >= t1_last(t1_div_q));

  // restarts on control write so a new divide takes a clean first period
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t1_pre_q <= 9'h000;
    end else if (wr_t1ctl) begin
      t1_pre_q <= 9'h000;
    end else if (t1_halt_q) begin
      t1_pre_q <= t1_pre_q;
    end else if (t1_step) begin
      t1_pre_q <= 9'h000;
    end else begin
      t1_pre_q <= t1_pre_q + 9'h001;
    end
  end

  // ----------------------------------------------------------------------
  // timer one count
  // ----------------------------------------------------------------------
  logic t1_wrap;

  assign t1_wrap = t1_step && (t1_count_q == 8'hFF);

  // software write wins over a step in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t1_count_q <= `TMRCTL_RST_T1_COUNT;
    end else if (wr_count) begin
      t1_count_q <= i_wdata;
    end else if (t1_wrap) begin
      t1_count_q <= t1_reload_q;
    end else if (t1_step) begin
      t1_count_q <= t1_count_q + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_t1_overflow <= 1'b0;
    end else begin
      o_t1_overflow <= t1_wrap && !wr_count;
    end
  end

  assign o_t1_count = t1_count_q;

  // ----------------------------------------------------------------------
  // second timer sources
  // ----------------------------------------------------------------------
  // source pins are sampled levels; a rising level is one tick
  logic       slow_prev_q;
  logic       frc_prev_q;
  logic [6:0] sys128_q;
  logic [8:0] frc512_q;
  logic       slow_tick;
  logic       frc_edge;
  logic       sys128_tick;
  logic       frc512_tick;
  logic       src_tick;

  assign slow_tick   = rise(i_slow_clk, slow_prev_q);
  assign frc_edge    = rise(i_fast_rc_clk, frc_prev_q);
  assign sys128_tick = (sys128_q == `TMRCTL_SYS128_LAST);
  assign frc512_tick = frc_edge && (frc512_q == `TMRCTL_FRC512_LAST);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= i_slow_clk;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frc_prev_q <= 1'b0;
    end else begin
      frc_prev_q <= i_fast_rc_clk;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sys128_q <= 7'h00;
    end else if (t2_clr_q) begin
      sys128_q <= 7'h00;
    end else begin
      sys128_q <= sys128_q + 7'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frc512_q <= 9'h000;
    end else if (t2_clr_q) begin
      frc512_q <= 9'h000;
    end else if (frc_edge) begin
      frc512_q <= frc512_q + 9'h001;
    end
  end

  // code 01 taken as system over 128; both 1x codes pick the fast rc path
  always_comb begin
    case (t2_src_q)
      tmrctl_pkg::TMRCTL_SRC_SLOW:   src_tick = slow_tick;
      tmrctl_pkg::TMRCTL_SRC_SYS128: src_tick = sys128_tick;
      tmrctl_pkg::TMRCTL_SRC_FRC0,
      tmrctl_pkg::TMRCTL_SRC_FRC1:   src_tick = frc512_tick;
      default:                       src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // second timer divider
  // ----------------------------------------------------------------------
  // clear holds the divider count at zero until software releases it
  tmrctl_t2_divider u_t2_divider (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_src_tick (src_tick),
    .i_clear    (t2_clr_q),
    .i_div_sel  (t2_div_q),
    .o_count    (o_t2_count),
    .o_overflow (o_t2_overflow)
  );

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  logic [7:0] rd_d;

  always_comb begin
    rd_d = 8'h00;
    if (hit(i_addr, `TMRCTL_ADDR_T1_COUNT)) begin
      rd_d = t1_count_q;
    end else if (hit(i_addr, `TMRCTL_ADDR_T1_RELOAD)) begin
      rd_d = t1_reload_q;
    end else if (hit(i_addr, `TMRCTL_ADDR_T1_CTL)) begin
      rd_d = t1_ctl_image(t1_halt_q, t1_div_q);
    end else if (hit(i_addr, `TMRCTL_ADDR_T2_CTL)) begin
      rd_d = t2_ctl_image(t2_clr_q, t2_src_q, t2_div_q);
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule : tmrctl_top

/* File: hw/tmrctl_params.svh */
/*
  Constants of the two-timer control block: register offsets, field
  positions, reset values and divider figures.
  Assumes: included by bare name from the design modules.
*/
`ifndef TMRCTL_PARAMS_SVH
`define TMRCTL_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TMRCTL_ADDR_T1_COUNT   8'h12
`define TMRCTL_ADDR_T1_RELOAD  8'h13
`define TMRCTL_ADDR_T1_CTL     8'h14
`define TMRCTL_ADDR_T2_CTL     8'h15

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TMRCTL_T1_HALT_BIT     6
`define TMRCTL_T1_DIV_MSB      3
`define TMRCTL_T1_DIV_LSB      0
`define TMRCTL_T2_CLR_BIT      4
`define TMRCTL_T2_CKS_MSB      3
`define TMRCTL_T2_CKS_LSB      2
`define TMRCTL_T2_DIV_MSB      1
`define TMRCTL_T2_DIV_LSB      0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TMRCTL_RST_T1_COUNT    8'h00
`define TMRCTL_RST_T1_RELOAD   8'h00
`define TMRCTL_RST_T1_HALT     1'h0
`define TMRCTL_RST_T1_DIV      4'h0
`define TMRCTL_RST_T2_CLR      1'h0
`define TMRCTL_RST_T2_CKS      2'h0
`define TMRCTL_RST_T2_DIV      2'h0

// ----------------------------------------------------------------------
// divider figures
// ----------------------------------------------------------------------
`define TMRCTL_SYS_PRE_DIV     9'h002
`define TMRCTL_SYS128_LAST     7'h7F
`define TMRCTL_FRC512_LAST     9'h1FF
`define TMRCTL_T2_DIV_32768    16'h8000
`define TMRCTL_T2_DIV_16384    16'h4000
`define TMRCTL_T2_DIV_8192     16'h2000
`define TMRCTL_T2_DIV_128      16'h0080

`endif

/* File: hw/tmrctl_pkg.sv */
/*
  Types of the two-timer control block.
  Assumes: nothing beyond the params header.
*/
package tmrctl_pkg;

  // ----------------------------------------------------------------------
  // second timer clock source
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TMRCTL_SRC_SLOW   = 2'b00,
    TMRCTL_SRC_SYS128 = 2'b01,
    TMRCTL_SRC_FRC0   = 2'b10,
    TMRCTL_SRC_FRC1   = 2'b11
  } tmrctl_src_t;

endpackage : tmrctl_pkg

/* File: hw/tmrctl_t2_divider.sv */
/*
  Second timer divider: counts source ticks and pulses once per selected
  divide figure.
  Assumes: source tick is a one-cycle pulse on i_core_clk.
*/
`include "tmrctl_params.svh"

module tmrctl_t2_divider (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_src_tick,
  input  wire logic        i_clear,
  input  wire logic [1:0]  i_div_sel,
  output logic      [14:0] o_count,
  output logic             o_overflow
);

  // ----------------------------------------------------------------------
  // divide figure
  // ----------------------------------------------------------------------
  function automatic logic [15:0] t2_last(input logic [1:0] sel);
    case (sel)
      2'b00:   t2_last = `TMRCTL_T2_DIV_32768 - 16'h0001;
      2'b01:   t2_last = `TMRCTL_T2_DIV_16384 - 16'h0001;
      2'b10:   t2_last = `TMRCTL_T2_DIV_8192 - 16'h0001;
      default: t2_last = `TMRCTL_T2_DIV_128 - 16'h0001;
    endcase
  endfunction : t2_last

  logic [14:0] cnt_q;
  logic        wrap;

  assign wrap = ({1'b0, cnt_q} >= t2_last(i_div_sel));

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 15'h0000;
    end else if (i_clear) begin
      cnt_q <= 15'h0000;
    end else if (i_src_tick) begin
      cnt_q <= wrap ? 15'h0000 : cnt_q + 15'h0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overflow <= 1'b0;
    end else begin
      o_overflow <= !i_clear && i_src_tick && wrap;
    end
  end

  assign o_count = cnt_q;

endmodule : tmrctl_t2_divider

/* File: verification/tmrctl_top_sva.sv */
/*
  Port checker for the two-timer control block.
  Assumes: bound to tmrctl_top by the bind after the module.
*/
module tmrctl_top_sva (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_t1_overflow,
  input wire logic [7:0]  o_t1_count,
  input wire logic        o_t2_overflow,
  input wire logic [14:0] o_t2_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic halt_q;
  logic clr_q;
  // ----------------------------------------------------------------------
  // control bits seen through writes
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halt_q <= 1'b0;
      clr_q  <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == 8'h14) halt_q <= i_wdata[6];
      if (i_addr == 8'h15) clr_q <= i_wdata[4];
    end
  end
  sequence s_t1_start;
    i_wr && i_addr == 8'h14 && i_wdata == 8'h00;
  endsequence
  sequence s_t1_quiet;
    s_t1_start ##1 (!i_wr && o_t1_count != 8'hFF) ##1 (!i_wr) [*2];
  endsequence
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_rdata_unmapped: assert property (
    i_rd && (i_addr < 8'h12 || i_addr > 8'h15) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_count_readback: assert property (
    i_rd && i_addr == 8'h12 |=> o_rdata == $past(o_t1_count))
    else $error("count readback wrong");
  a_count_write: assert property (
    i_wr && i_addr == 8'h12 |=> o_t1_count == $past(i_wdata))
    else $error("count write lost");
  a_t1_first_step: assert property (
    s_t1_quiet |-> $past(o_t1_count) == $past(o_t1_count, 2)
      && o_t1_count == $past(o_t1_count, 2) + 8'h01)
    else $error("timer one step timing wrong");
  a_t1_step_one: assert property (
    !$past(i_wr) && $changed(o_t1_count)
      |-> o_t1_count == $past(o_t1_count) + 8'h01 || $past(o_t1_count) == 8'hFF)
    else $error("timer one step not plus one");
  a_t1_ovf_source: assert property (
    o_t1_overflow |-> $past(o_t1_count) == 8'hFF || $past(o_t1_count, 2) == 8'hFF)
    else $error("overflow without wrap");
  a_t1_halt_frozen: assert property (halt_q && !i_wr |=> $stable(o_t1_count))
    else $error("halted count moved");
  a_t2_clr_holds: assert property (clr_q && !i_wr |=> o_t2_count == 15'h0000)
    else $error("cleared second timer not zero");
  a_t2_ovf_zero: assert property (o_t2_overflow |-> o_t2_count == 15'h0000)
    else $error("second timer overflow without wrap to zero");
  a_t2_step_one: assert property (
    $changed(o_t2_count)
      |-> o_t2_count == $past(o_t2_count) + 15'h0001 || o_t2_count == 15'h0000)
    else $error("second timer step not plus one");
endmodule : tmrctl_top_sva

bind tmrctl_top tmrctl_top_sva u_tmrctl_top_sva (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_t1_overflow(o_t1_overflow),
  .o_t1_count(o_t1_count), .o_t2_overflow(o_t2_overflow), .o_t2_count(o_t2_count));

/* File: verification/tmrctl_bench.sv */
/*
  Self-checking bench of the two-timer control block.
  Assumes: design files and checker compiled before it.
*/
module tmrctl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tmrctl_row_t;
  logic        i_core_clk, i_rst_n, i_wr, i_rd, i_slow_clk, i_fast_rc_clk;
  logic [7:0]  i_addr, i_wdata, o_rdata, o_t1_count, rd_v;
  logic        o_t1_overflow, o_t2_overflow;
  logic [14:0] o_t2_count;
  int          n_fail, cmp_count, cyc;
  int          t2_gap [4] = '{8, 128, 2048, 2048};
  tmrctl_row_t rows [7] = '{'{8'h14, 8'h4F, 8'h4F}, '{8'h13, 8'h3C, 8'h3C},
    '{8'h12, 8'hA5, 8'hA5}, '{8'h15, 8'hFF, 8'h1F}, '{8'h14, 8'hFF, 8'h4F},
    '{8'h16, 8'h55, 8'h00}, '{8'h11, 8'hAA, 8'h00}};
  tmrctl_top u_tmrctl_top (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_slow_clk(i_slow_clk), .i_fast_rc_clk(i_fast_rc_clk), .o_t1_overflow(o_t1_overflow),
    .o_t1_count(o_t1_count), .o_t2_overflow(o_t2_overflow), .o_t2_count(o_t2_count));
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  // slow clock period 8 cycles, fast rc period 4 cycles
  initial begin
    forever begin
      repeat (2) @(posedge i_core_clk);
      i_fast_rc_clk <= ~i_fast_rc_clk;
      repeat (2) @(posedge i_core_clk);
      i_fast_rc_clk <= ~i_fast_rc_clk;
      i_slow_clk    <= ~i_slow_clk;
    end
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
    @(posedge i_core_clk);
  endtask : rd
  // sel 0 t1 count change, 1 t2 count change, 2 t2 overflow, 3 t1 overflow
  task automatic wait_ev(input int sel);
    logic [14:0] last;
    last = (sel == 0) ? 15'(o_t1_count) : o_t2_count;
    cyc = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      cyc++;
    end while (cyc < 5000 && !(sel == 2 ? o_t2_overflow === 1'b1 :
      sel == 3 ? o_t1_overflow === 1'b1 :
      ((sel == 0) ? 15'(o_t1_count) : o_t2_count) !== last));
    if (cyc >= 5000) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_ev
  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_slow_clk = 1'b0;
    i_fast_rc_clk = 1'b0;
    repeat (3) @(posedge i_core_clk);
    chk(o_t1_count, 8'h00);
    chk({o_t2_count, o_rdata}, 0);
    i_rst_n <= 1'b1;
    for (int a = 8'h13; a <= 8'h15; a++) begin
      rd(8'(a));
      chk(rd_v, 8'h00);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rd_v, rows[i].e);
    end
    $display("register table test done");
    for (int d = 0; d < 16; d++) begin
      wr(8'h14, 8'h40);
      wr(8'h12, 8'h00);
      wr(8'h14, 8'(d));
      wait_ev(0);
      chk(cyc + 1, 2 * ((d >= 8) ? 256 : (1 << d)));
      @(posedge i_core_clk);
    end
    $display("prescaler test done");
    wr(8'h14, 8'h40);
    wr(8'h13, 8'h3C);
    wr(8'h12, 8'hFE);
    wr(8'h14, 8'h00);
    wait_ev(3);
    chk(o_t1_count, 8'h3C);
    @(posedge i_core_clk);
    wr(8'h14, 8'h40);
    wr(8'h12, 8'h77);
    repeat (40) @(posedge i_core_clk);
    rd(8'h12);
    chk(rd_v, 8'h77);
    $display("reload and halt test done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h15, 8'h03 | 8'(s << 2));
      wait_ev(1);
      wait_ev(1);
      chk(cyc, t2_gap[s]);
      @(posedge i_core_clk);
    end
    wr(8'h15, 8'h03);
    wait_ev(2);
    wait_ev(2);
    chk(cyc, 1024);
    @(posedge i_core_clk);
    wr(8'h15, 8'h10);
    repeat (300) @(posedge i_core_clk);
    chk(o_t2_count, 15'h0000);
    wr(8'h15, 8'h00);
    wait_ev(1);
    chk(o_t2_count, 15'h0001);
    // the large divide codes must not wrap where code 11 would
    for (int k = 0; k < 3; k++) begin
      @(posedge i_core_clk);
      wr(8'h15, 8'h10);
      wr(8'h15, 8'(k));
      repeat (200) wait_ev(1);
      chk(o_t2_count, 15'h00C8);
    end
    $display("second timer test done");
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    @(posedge i_core_clk);
    chk(o_t1_count, 8'h00);
    i_rst_n <= 1'b1;
    rd(8'h15);
    chk(rd_v, 8'h00);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule : tmrctl_bench
